// ==== rtl/lus_top.sv ====
// per-port line status, interrupt mask and receive configuration registers on avalon-mm
`include "lus_cfg.svh"

module lus_top
   import lus_pkg::*;
#(
   parameter int P = 16
) (
   input  wire logic                  sys_clk,
   input  wire logic                  sys_rst,
   input  wire logic [15:0]           avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   input  wire logic [3:0]            avs_byteenable,
   output logic      [31:0]           avs_readdata,
   output logic                       avs_waitrequest,
   input  wire logic [P-1:0]          signal_absent,
   input  wire logic [P-1:0]          tx_short_in,
   input  wire logic [P-1:0]          tx_open_in,
   input  wire logic [P-1:0]          jitter_trip_in,
   input  wire logic [P-1:0][3:0]     rx_level_code,
   input  wire logic [P-1:0]          short_haul,
   input  wire logic [P-1:0][3:0]     equalizer_gain_cap,
   input  wire logic [P-1:0][2:0]     tx_build_out_code,
   input  wire logic [P-1:0]          e1_mode,
   output logic      [P-1:0]          line_irq,
   output logic      [P-1:0]          ext_resistor_connect,
   output logic      [P-1:0]          internal_term_enable,
   output logic      [P-1:0][2:0]     rx_impedance_select,
   output logic      [P-1:0]          rx_clock_input_mode,
   output logic      [P-1:0]          rx_turns_ratio,
   output logic      [P-1:0]          monitor_mode_enable,
   output logic      [P-1:0][1:0]     rx_sensitivity_select,
   output logic      [P-1:0][8:0]     rx_max_loss_tenth_db,
   output logic      [P-1:0][5:0]     monitor_gain_db
);

   localparam int PW = (P > 1) ? $clog2(P) : 1;

   // -----------------------------------------------------------------------------
   // functions
   // -----------------------------------------------------------------------------

   // word index of one register of one zero-based port
   function automatic logic [13:0] lus_reg_index(input int unsigned port, input logic [13:0] off);
      logic [31:0] a;
      a = 32'(off) + 32'(port) * 32'(`LUS_PORT_STRIDE)
          + (32'(port) / 32'(`LUS_PORTS_PER_BANK)) * 32'(`LUS_BANK_STRIDE);
      return a[13:0];
   endfunction

   // allowed cable loss for a sensitivity code, in tenths of a dB
   function automatic logic [8:0] lus_max_loss(input logic mon, input logic [1:0] sel, input logic e1);
      logic [8:0] v;
      v = `LUS_LOSS_N0;
      if (mon) begin
         unique case (sel)
            2'h0: v = `LUS_LOSS_M0;
            2'h1: v = `LUS_LOSS_M1;
            2'h2: v = `LUS_LOSS_M2;
            2'h3: v = `LUS_LOSS_M3;
         endcase
      end else begin
         unique case (sel)
            2'h0: v = `LUS_LOSS_N0;
            2'h1: v = `LUS_LOSS_N1;
            2'h2: v = `LUS_LOSS_N2;
            2'h3: v = e1 ? `LUS_LOSS_N3_E1 : `LUS_LOSS_N3_T1;
         endcase
      end
      return v;
   endfunction

   // monitor gain in dB, zero when monitor mode is off
   function automatic logic [5:0] lus_mon_gain(input logic mon, input logic [1:0] sel);
      logic [5:0] g;
      g = `LUS_GAIN_OFF;
      if (mon) begin
         unique case (sel)
            2'h0: g = `LUS_GAIN_M0;
            2'h1: g = `LUS_GAIN_M1;
            2'h2: g = `LUS_GAIN_M2;
            2'h3: g = `LUS_GAIN_M3;
         endcase
      end
      return g;
   endfunction

   // -----------------------------------------------------------------------------
   // address decode
   // -----------------------------------------------------------------------------
   lus_reg_t          sel_reg;
   logic [PW-1:0]     sel_port;
   logic [13:0]       word_idx;

   // linear search over ports; the address map has gaps, so no shortcut is safe
   always_comb begin
      word_idx = avs_address[15:2];
      sel_reg  = LUS_REG_NONE;
      sel_port = '0;
      for (int unsigned p = 0; p < P; p++) begin
         if (word_idx == lus_reg_index(p, `LUS_OFF_MASK)) begin
            sel_reg  = LUS_REG_MASK;
            sel_port = PW'(p);
         end
         if (word_idx == lus_reg_index(p, `LUS_OFF_LATCH)) begin
            sel_reg  = LUS_REG_LATCH;
            sel_port = PW'(p);
         end
         if (word_idx == lus_reg_index(p, `LUS_OFF_LEVEL)) begin
            sel_reg  = LUS_REG_LEVEL;
            sel_port = PW'(p);
         end
         if (word_idx == lus_reg_index(p, `LUS_OFF_TERM)) begin
            sel_reg  = LUS_REG_TERM;
            sel_port = PW'(p);
         end
         if (word_idx == lus_reg_index(p, `LUS_OFF_RXCTL)) begin
            sel_reg  = LUS_REG_RXCTL;
            sel_port = PW'(p);
         end
      end
   end

   // -----------------------------------------------------------------------------
   // bus handshake
   // -----------------------------------------------------------------------------
   logic              ack_ff;
   logic              nxt_ack;
   logic [7:0]        rdata_ff;
   logic [7:0]        nxt_rdata;
   logic              wr_en;
   logic [7:0]        wbyte;

   logic [P-1:0][7:0] mask_ff;
   logic [P-1:0][7:0] latch_ff;
   logic [P-1:0][7:0] term_ff;
   logic [P-1:0][7:0] rxctl_ff;
   logic [P-1:0][3:0] level_ff;

   // one wait state: read data is captured at the first edge, answered at the second
   always_comb begin
      nxt_ack   = (avs_read | avs_write) & ~ack_ff;
      nxt_rdata = rdata_ff;
      if (avs_read && !ack_ff) begin
         unique case (sel_reg)
            LUS_REG_MASK:  nxt_rdata = mask_ff[sel_port];
            LUS_REG_LATCH: nxt_rdata = latch_ff[sel_port];
            LUS_REG_LEVEL: nxt_rdata = {level_ff[sel_port], 4'h0};
            LUS_REG_TERM:  nxt_rdata = term_ff[sel_port];
            LUS_REG_RXCTL: nxt_rdata = rxctl_ff[sel_port];
            LUS_REG_NONE:  nxt_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ack_ff   <= 1'b0;
         rdata_ff <= `LUS_RST_BYTE;
      end else begin
         ack_ff   <= nxt_ack;
         rdata_ff <= nxt_rdata;
      end
   end

   // writes take effect only at the edge that ends the wait, lane 0 carries the byte
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
   assign avs_readdata    = {24'h000000, rdata_ff};
   assign wr_en           = avs_write & ack_ff & avs_byteenable[0];
   assign wbyte           = avs_writedata[7:0];

   // -----------------------------------------------------------------------------
   // condition synchronisers and edge detection
   // -----------------------------------------------------------------------------
   logic [P-1:0][3:0] cond_s1_ff;
   logic [P-1:0][3:0] cond_s2_ff;
   logic [P-1:0][3:0] cond_prev_ff;
   logic [P-1:0][3:0] lvl_s1_ff;
   logic [P-1:0][3:0] lvl_s2_ff;
   logic [P-1:0][3:0] nxt_cond_s1;
   logic [P-1:0][3:0] nxt_lvl_s1;
   logic [P-1:0][3:0] nxt_level;

   // raw pins bundled per port in latched-bit order
   always_comb begin
      for (int p = 0; p < P; p++) begin
         nxt_cond_s1[p][`LUS_COND_LOSS]   = signal_absent[p];
         nxt_cond_s1[p][`LUS_COND_SHORT]  = tx_short_in[p];
         nxt_cond_s1[p][`LUS_COND_OPEN]   = tx_open_in[p];
         nxt_cond_s1[p][`LUS_COND_JITTER] = jitter_trip_in[p];
         nxt_lvl_s1[p]                    = rx_level_code[p];
         // the level code may tear for one sample during a change; it is a live reading
         nxt_level[p] = lvl_s2_ff[p];
         if (short_haul[p] && (lvl_s2_ff[p] > equalizer_gain_cap[p])) begin
            nxt_level[p] = equalizer_gain_cap[p];
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cond_s1_ff   <= '0;
         cond_s2_ff   <= '0;
         cond_prev_ff <= '0;
         lvl_s1_ff    <= '0;
         lvl_s2_ff    <= '0;
         level_ff     <= '0;
      end else begin
         cond_s1_ff   <= nxt_cond_s1;
         cond_s2_ff   <= cond_s1_ff;
         cond_prev_ff <= cond_s2_ff;
         lvl_s1_ff    <= nxt_lvl_s1;
         lvl_s2_ff    <= lvl_s1_ff;
         level_ff     <= nxt_level;
      end
   end

   // -----------------------------------------------------------------------------
   // register file
   // -----------------------------------------------------------------------------
   logic [P-1:0][7:0] nxt_mask;
   logic [P-1:0][7:0] nxt_latch;
   logic [P-1:0][7:0] nxt_term;
   logic [P-1:0][7:0] nxt_rxctl;
   logic [P-1:0][3:0] rise;
   logic [P-1:0][3:0] fall;
   logic [P-1:0][7:0] set_ev;
   logic [P-1:0][7:0] clr_ev;
   logic [P-1:0]      csu_shape;

   // set wins over a same-cycle write-one-to-clear so no event is lost
   always_comb begin
      for (int p = 0; p < P; p++) begin
         rise[p]      = cond_s2_ff[p] & ~cond_prev_ff[p];
         fall[p]      = ~cond_s2_ff[p] & cond_prev_ff[p];
         csu_shape[p] = tx_build_out_code[p] >= `LUS_CSU_FIRST;
         set_ev[p][`LUS_COND_LOSS]   = rise[p][`LUS_COND_LOSS];
         set_ev[p][`LUS_COND_SHORT]  = rise[p][`LUS_COND_SHORT] & ~csu_shape[p];
         set_ev[p][`LUS_COND_OPEN]   = rise[p][`LUS_COND_OPEN] & ~csu_shape[p];
         set_ev[p][`LUS_COND_JITTER] = rise[p][`LUS_COND_JITTER];
         set_ev[p][`LUS_CLEAR_SHIFT + `LUS_COND_LOSS]   = fall[p][`LUS_COND_LOSS];
         set_ev[p][`LUS_CLEAR_SHIFT + `LUS_COND_SHORT]  = fall[p][`LUS_COND_SHORT];
         set_ev[p][`LUS_CLEAR_SHIFT + `LUS_COND_OPEN]   = fall[p][`LUS_COND_OPEN];
         set_ev[p][`LUS_CLEAR_SHIFT + `LUS_COND_JITTER] = fall[p][`LUS_COND_JITTER];
         clr_ev[p]    = 8'h00;
         nxt_mask[p]  = mask_ff[p];
         nxt_term[p]  = term_ff[p];
         nxt_rxctl[p] = rxctl_ff[p];
         if (wr_en && (sel_port == PW'(p))) begin
            unique case (sel_reg)
               LUS_REG_MASK:  nxt_mask[p]  = wbyte;
               LUS_REG_LATCH: clr_ev[p]    = wbyte;
               LUS_REG_TERM:  nxt_term[p]  = wbyte & `LUS_TERM_WMASK;
               LUS_REG_RXCTL: nxt_rxctl[p] = wbyte & `LUS_RXCTL_WMASK;
               LUS_REG_LEVEL: nxt_mask[p]  = mask_ff[p];
               LUS_REG_NONE:  nxt_mask[p]  = mask_ff[p];
            endcase
         end
         nxt_latch[p] = (latch_ff[p] & ~clr_ev[p]) | set_ev[p];
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mask_ff  <= '0;
         latch_ff <= '0;
         term_ff  <= '0;
         rxctl_ff <= '0;
      end else begin
         mask_ff  <= nxt_mask;
         latch_ff <= nxt_latch;
         term_ff  <= nxt_term;
         rxctl_ff <= nxt_rxctl;
      end
   end

   // -----------------------------------------------------------------------------
   // registered control outputs and interrupt
   // -----------------------------------------------------------------------------
   logic [P-1:0]      irq_ff;
   logic [P-1:0]      ext_ff;
   logic [P-1:0]      int_ff;
   logic [P-1:0][2:0] imp_ff;
   logic [P-1:0]      clkin_ff;
   logic [P-1:0]      ratio_ff;
   logic [P-1:0]      mon_ff;
   logic [P-1:0][1:0] sens_ff;
   logic [P-1:0][8:0] loss_ff;
   logic [P-1:0][5:0] gain_ff;
   logic [P-1:0]      nxt_irq;
   logic [P-1:0]      nxt_ext;
   logic [P-1:0]      nxt_int;
   logic [P-1:0][2:0] nxt_imp;
   logic [P-1:0]      nxt_clkin;
   logic [P-1:0]      nxt_ratio;
   logic [P-1:0]      nxt_mon;
   logic [P-1:0][1:0] nxt_sens;
   logic [P-1:0][8:0] nxt_loss;
   logic [P-1:0][5:0] nxt_gain;

   // outputs follow the registers one cycle later; the analog side sees no glitches
   always_comb begin
      for (int p = 0; p < P; p++) begin
         nxt_irq[p]   = |(latch_ff[p] & mask_ff[p]);
         nxt_ext[p]   = term_ff[p][`LUS_TERM_EXT];
         // a reserved code or the 2:1 ratio keeps the internal match off
         nxt_int[p]   = term_ff[p][`LUS_TERM_INT]
                        & ~term_ff[p][`LUS_TERM_IMP_MSB]
                        & ~rxctl_ff[p][`LUS_RXCTL_RATIO];
         nxt_imp[p]   = term_ff[p][`LUS_TERM_IMP_MSB:0];
         nxt_clkin[p] = rxctl_ff[p][`LUS_RXCTL_CLKIN];
         nxt_ratio[p] = rxctl_ff[p][`LUS_RXCTL_RATIO];
         nxt_mon[p]   = rxctl_ff[p][`LUS_RXCTL_MON];
         nxt_sens[p]  = rxctl_ff[p][`LUS_RXCTL_SENS_LSB +: 2];
         nxt_loss[p]  = lus_max_loss(nxt_mon[p], nxt_sens[p], e1_mode[p]);
         nxt_gain[p]  = lus_mon_gain(nxt_mon[p], nxt_sens[p]);
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_ff   <= '0;
         ext_ff   <= '0;
         int_ff   <= '0;
         imp_ff   <= '0;
         clkin_ff <= '0;
         ratio_ff <= '0;
         mon_ff   <= '0;
         sens_ff  <= '0;
         loss_ff  <= {P{`LUS_LOSS_N0}};
         gain_ff  <= {P{`LUS_GAIN_OFF}};
      end else begin
         irq_ff   <= nxt_irq;
         ext_ff   <= nxt_ext;
         int_ff   <= nxt_int;
         imp_ff   <= nxt_imp;
         clkin_ff <= nxt_clkin;
         ratio_ff <= nxt_ratio;
         mon_ff   <= nxt_mon;
         sens_ff  <= nxt_sens;
         loss_ff  <= nxt_loss;
         gain_ff  <= nxt_gain;
      end
   end

   // port wiring
   assign line_irq              = irq_ff;
   assign ext_resistor_connect  = ext_ff;
   assign internal_term_enable  = int_ff;
   assign rx_impedance_select   = imp_ff;
   assign rx_clock_input_mode   = clkin_ff;
   assign rx_turns_ratio        = ratio_ff;
   assign monitor_mode_enable   = mon_ff;
   assign rx_sensitivity_select = sens_ff;
   assign rx_max_loss_tenth_db  = loss_ff;
   assign monitor_gain_db       = gain_ff;

endmodule

// ==== rtl/lus_cfg.svh ====
// register offsets, field positions, reset values and tables of the line status block
`ifndef LUS_CFG_SVH
`define LUS_CFG_SVH

// -----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// -----------------------------------------------------------------------------
`define LUS_OFF_MASK        14'h1004
`define LUS_OFF_LATCH       14'h1005
`define LUS_OFF_LEVEL       14'h1006
`define LUS_OFF_TERM        14'h1007
`define LUS_OFF_RXCTL       14'h1008
`define LUS_PORT_STRIDE     14'h0020
`define LUS_BANK_STRIDE     14'h2000
`define LUS_PORTS_PER_BANK  5'h08

// -----------------------------------------------------------------------------
// field positions
// -----------------------------------------------------------------------------
`define LUS_COND_LOSS       0
`define LUS_COND_SHORT      1
`define LUS_COND_OPEN       2
`define LUS_COND_JITTER     3
`define LUS_CLEAR_SHIFT     4
`define LUS_LEVEL_LSB       4
`define LUS_TERM_EXT        7
`define LUS_TERM_INT        6
`define LUS_TERM_IMP_MSB    2
`define LUS_RXCTL_CLKIN     7
`define LUS_RXCTL_RATIO     3
`define LUS_RXCTL_MON       2
`define LUS_RXCTL_SENS_LSB  0

// -----------------------------------------------------------------------------
// reset values and writable masks
// -----------------------------------------------------------------------------
`define LUS_RST_BYTE        8'h00
`define LUS_TERM_WMASK      8'hC7
`define LUS_RXCTL_WMASK     8'h8F
`define LUS_CSU_FIRST       3'h5

// -----------------------------------------------------------------------------
// sensitivity tables: loss in tenths of a dB, monitor gain in dB
// -----------------------------------------------------------------------------
`define LUS_LOSS_N0         9'h078
`define LUS_LOSS_N1         9'h0C8
`define LUS_LOSS_N2         9'h12C
`define LUS_LOSS_N3_T1      9'h168
`define LUS_LOSS_N3_E1      9'h1AE
`define LUS_LOSS_M0         9'h12C
`define LUS_LOSS_M1         9'h0E1
`define LUS_LOSS_M2         9'h0AF
`define LUS_LOSS_M3         9'h078
`define LUS_GAIN_M0         6'h0E
`define LUS_GAIN_M1         6'h14
`define LUS_GAIN_M2         6'h1A
`define LUS_GAIN_M3         6'h20
`define LUS_GAIN_OFF        6'h00

`endif

// ==== rtl/lus_pkg.sv ====
// types shared by the line status block
package lus_pkg;

   // -----------------------------------------------------------------------------
   // register selected by a bus access
   // -----------------------------------------------------------------------------
   typedef enum logic [2:0] {
      LUS_REG_NONE,
      LUS_REG_MASK,
      LUS_REG_LATCH,
      LUS_REG_LEVEL,
      LUS_REG_TERM,
      LUS_REG_RXCTL
   } lus_reg_t;

endpackage

// ==== sim/lus_top_assertions.sv ====
// bound checker for the bus, termination and receive configuration ports
module lus_top_assertions
   import lus_pkg::*;
#(
   parameter int P = 16
) (
   input wire logic               sys_clk,
   input wire logic               sys_rst,
   input wire logic [15:0]        avs_address,
   input wire logic               avs_read,
   input wire logic               avs_write,
   input wire logic [31:0]        avs_writedata,
   input wire logic [3:0]         avs_byteenable,
   input wire logic [31:0]        avs_readdata,
   input wire logic               avs_waitrequest,
   input wire logic [P-1:0]       e1_mode,
   input wire logic [P-1:0]       ext_resistor_connect,
   input wire logic [P-1:0]       internal_term_enable,
   input wire logic [P-1:0][2:0]  rx_impedance_select,
   input wire logic [P-1:0]       rx_clock_input_mode,
   input wire logic [P-1:0]       rx_turns_ratio,
   input wire logic [P-1:0]       monitor_mode_enable,
   input wire logic [P-1:0][1:0]  rx_sensitivity_select,
   input wire logic [P-1:0][8:0]  rx_max_loss_tenth_db,
   input wire logic [P-1:0][5:0]  monitor_gain_db
);
   timeunit 1ns;
   timeprecision 1ns;

   // loss in tenths of a db, indexed by {monitor, code}; t1 value at code 3
   localparam logic [8:0] LOSS_T [8] = '{9'h078, 9'h0C8, 9'h12C, 9'h168, 9'h12C, 9'h0E1, 9'h0AF, 9'h078};

   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   // -------------------------------------
   // bus handshake
   // -------------------------------------
   wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("waitrequest held past one cycle");
   idle_ready_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
      else $error("waitrequest high while idle");
   read_upper_a: assert property (avs_readdata[31:8] == 24'h000000)
      else $error("upper read bytes not zero");
   // read data only changes at a read capture edge
   read_hold_a: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
      else $error("read data moved without a read");
   // control outputs of port zero follow a write two edges after the answer
   ctl_follow_a: assert property (
      avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == 16'h4020 |=> ##1
      {rx_clock_input_mode[0], rx_turns_ratio[0], monitor_mode_enable[0], rx_sensitivity_select[0]}
      == {$past(avs_writedata[7], 2), $past(avs_writedata[3:0], 2)})
      else $error("receive control outputs wrong");
   term_follow_a: assert property (
      avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == 16'h401C |=> ##1
      {ext_resistor_connect[0], rx_impedance_select[0]} == {$past(avs_writedata[7], 2), $past(avs_writedata[2:0], 2)})
      else $error("termination outputs wrong");

   // -------------------------------------
   // per-port decoded settings
   // -------------------------------------
   for (genvar i = 0; i < P; i++) begin : g_port
      term_excl_a: assert property (
         !(internal_term_enable[i] && (rx_turns_ratio[i] || rx_impedance_select[i][2])))
         else $error("internal termination in excluded setting");
      gain_map_a: assert property (
         monitor_gain_db[i] == (monitor_mode_enable[i] ? 6'h0E + 6'h06 * {4'h0, rx_sensitivity_select[i]} : 6'h00))
         else $error("monitor gain wrong");
      loss_map_a: assert property ($stable(e1_mode[i]) |-> rx_max_loss_tenth_db[i] ==
         (({monitor_mode_enable[i], rx_sensitivity_select[i]} == 3'h3 && e1_mode[i]) ? 9'h1AE :
          LOSS_T[{monitor_mode_enable[i], rx_sensitivity_select[i]}]))
         else $error("allowed loss wrong");
   end
endmodule

bind lus_top lus_top_assertions #(.P(P)) u_lus_chk (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .e1_mode(e1_mode),
   .ext_resistor_connect(ext_resistor_connect), .internal_term_enable(internal_term_enable),
   .rx_impedance_select(rx_impedance_select), .rx_clock_input_mode(rx_clock_input_mode),
   .rx_turns_ratio(rx_turns_ratio), .monitor_mode_enable(monitor_mode_enable),
   .rx_sensitivity_select(rx_sensitivity_select), .rx_max_loss_tenth_db(rx_max_loss_tenth_db),
   .monitor_gain_db(monitor_gain_db)
);

// ==== sim/tb.sv ====
// self-checking bench of the line status and receive configuration registers
module tb;
   timeunit 1ns;
   timeprecision 1ns;

   // -------------------------------------
   // stimulus and observed signals
   // -------------------------------------
   logic             sys_clk = 1'b0;
   logic             sys_rst = 1'b1;
   logic [15:0]      addr = 16'h0000;
   logic             rd_en = 1'b0;
   logic             wr_en = 1'b0;
   logic [31:0]      wdata = 32'h0;
   logic [3:0]       be = 4'hF;
   logic [31:0]      rdata;
   logic             wait_req;
   logic [15:0]      cond [4] = '{default: 16'h0}; // index equals the onset bit
   logic [15:0][3:0] lvl = 64'h0;
   logic [15:0][3:0] cap = 64'h0;
   logic [15:0][2:0] shape = 48'h0;
   logic [15:0]      sh = 16'h0;
   logic [15:0]      e1 = 16'h0;
   logic [15:0]      irq, ext, ite, rcm, ratio, mon;
   logic [15:0][2:0] imp;
   logic [15:0][1:0] sens;
   logic [31:0]      lfsr = 32'd65877;
   logic [7:0]       m [16];
   logic [7:0]       d, t, b;
   int               p, c, cyc = 0;
   int               err_total = 0;
   int               compares = 0;

   lus_top #(.P(16)) dut (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(addr), .avs_read(rd_en), .avs_write(wr_en),
      .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wait_req),
      .signal_absent(cond[0]), .tx_short_in(cond[1]), .tx_open_in(cond[2]), .jitter_trip_in(cond[3]),
      .rx_level_code(lvl), .short_haul(sh), .equalizer_gain_cap(cap), .tx_build_out_code(shape),
      .e1_mode(e1), .line_irq(irq), .ext_resistor_connect(ext), .internal_term_enable(ite),
      .rx_impedance_select(imp), .rx_clock_input_mode(rcm), .rx_turns_ratio(ratio), .monitor_mode_enable(mon),
      .rx_sensitivity_select(sens), .rx_max_loss_tenth_db(), .monitor_gain_db()
   );

   always #5 sys_clk = ~sys_clk;

   // watchdog so a stuck handshake still ends in a verdict
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         $display("[ERR] %0t timeout", $time);
         err_total++;
         results();
      end
   end

   // -------------------------------------
   // helpers
   // -------------------------------------
   function automatic logic [31:0] nx(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [15:0] adr(int n, int off);
      return 16'(4 * (off + 32'h20 * n + 32'h2000 * (n / 8)));
   endfunction
   // short haul caps the reported code at the gain limit
   function automatic logic [7:0] lvl_exp(logic [3:0] v, logic s, logic [3:0] k);
      return {(s && v > k) ? k : v, 4'h0};
   endfunction
   task automatic results();
      if (err_total == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one avalon access; request held until waitrequest is seen low at an edge
   task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] dv, output logic [7:0] q);
      addr <= a;
      wdata <= {24'h000000, dv};
      wr_en <= w;
      rd_en <= ~w;
      do @(posedge sys_clk); while (wait_req !== 1'b0);
      q = rdata[7:0];
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] dv);
      logic [7:0] q;
      bus(1'b1, a, dv, q);
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, q);
      check(q, e);
   endtask
   task automatic settle();
      repeat (8) @(posedge sys_clk);
   endtask

   // -------------------------------------
   // main sequence
   // -------------------------------------
   initial begin
      lfsr = nx(lfsr);
      e1 <= lfsr[15:0];
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      // every port: reset value, random settings, decoded outputs
      for (p = 0; p < 16; p++) begin
         rd(adr(p, 'h1005), 8'h00);
         lfsr = nx(lfsr);
         d = lfsr[7:0];
         t = lfsr[15:8];
         m[p] = lfsr[23:16];
         wr(adr(p, 'h1004), m[p]);
         wr(adr(p, 'h1008), d);
         rd(adr(p, 'h1008), d & 8'h8F);
         wr(adr(p, 'h1007), t);
         rd(adr(p, 'h1007), t & 8'hC7);
         check({3'h0, rcm[p], ratio[p], mon[p], sens[p]}, {3'h0, d[7], d[3:0]});
         check({3'h0, ext[p], ite[p], imp[p]}, {3'h0, t[7], t[6] & ~t[2] & ~d[3], t[2:0]});
      end
      // aliasing between ports would show here
      for (p = 0; p < 16; p++) rd(adr(p, 'h1004), m[p]);
      wr(16'h4000, 8'hFF);
      rd(16'h4000, 8'h00);
      be <= 4'hE;
      wr(adr(0, 'h1004), ~m[0]);
      be <= 4'hF;
      rd(adr(0, 'h1004), m[0]);
      // onset and removal of each condition on a second-bank port
      p = 9;
      for (c = 0; c < 4; c++) begin
         b = 8'h01 << c;
         wr(adr(p, 'h1004), b);
         cond[c][p] <= 1'b1;
         settle();
         rd(adr(p, 'h1005), b);
         check({7'h0, irq[p]}, 8'h01);
         wr(adr(p, 'h1005), 8'h00);
         rd(adr(p, 'h1005), b);
         wr(adr(p, 'h1005), b);
         rd(adr(p, 'h1005), 8'h00);
         check({7'h0, irq[p]}, 8'h00);
         cond[c][p] <= 1'b0;
         settle();
         rd(adr(p, 'h1005), b << 4);
         check({7'h0, irq[p]}, 8'h00);
         wr(adr(p, 'h1004), b << 4);
         rd(adr(p, 'h1005), b << 4);
         check({7'h0, irq[p]}, 8'h01);
         wr(adr(p, 'h1005), 8'hFF);
         rd(adr(p, 'h1005), 8'h00);
      end
      // csu build-out hides open and short onsets, not their removal
      lfsr = nx(lfsr);
      shape[p] <= 3'h5 + 3'(lfsr[1:0] % 2'h3);
      cond[1][p] <= 1'b1;
      cond[2][p] <= 1'b1;
      settle();
      rd(adr(p, 'h1005), 8'h00);
      cond[1][p] <= 1'b0;
      cond[2][p] <= 1'b0;
      settle();
      rd(adr(p, 'h1005), 8'h60);
      shape[p] <= 3'h0;
      // live level code, capped in short haul; writes there are ignored
      for (c = 0; c < 8; c++) begin
         lfsr = nx(lfsr);
         d = (c == 0) ? 8'h0F : lfsr[7:0];
         t = lfsr[15:8];
         lvl[p] <= d[3:0];
         sh[p] <= (c == 1) ? 1'b1 : t[0];
         cap[p] <= t[7:4];
         settle();
         wr(adr(p, 'h1006), 8'hFF);
         rd(adr(p, 'h1006), lvl_exp(d[3:0], (c == 1) ? 1'b1 : t[0], t[7:4]));
      end
      results();
   end
endmodule
